// ===== src/cc_chan.sv
// Capture/compare channels of a 16-bit timer unit: six compare outputs,
// four capture inputs, shadow control and compare output register.
// Assumes base timer counts, overflow pulses and reload values arrive on
// clk; capture pins are asynchronous and synchronised here.
//
// Overview of operation
// - Six compare channels, full 16-bit PWM resolution
// - Four captures; every channel enabled on its own
// - Capture mode per channel; function from enables
// - Even channels group A, odd group B
// - Capture edge rising, falling or both
// - Output undriven until enabled, initial value latched
// - Match of value and count changes output
// - One compare mode field for all channels
// - Pin updates in the match cycle
// - Match level while equal; rising edge acts
// - Compare registers loaded only by shadow transfer
// - Overflow trigger loads on base timer overflow
// - Software trigger: output bit set, cleared next
// - Transfer on trigger rising edge
// - Overflow trigger clears software trigger bit
// - Software trigger off: bits reach hidden register
// - Mode 0 enable: active if count at least value
// - Active level from group polarity bit
// - Mode 0: match to active, overflow inactive
// - Value equal reload keeps output active
// - Channels 0..3 raise external interrupt lines
`default_nettype none

`include "cc_consts.svh"

module cc_chan #(
	parameter int NUM_CMP = `CC_NUM_CMP,
	parameter int NUM_CAP = `CC_NUM_CAP,
	parameter int TW = `CC_TIMER_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [NUM_CMP-1:0][TW-1:0] chan_count,
	input wire logic [NUM_CMP-1:0] chan_ovf,
	input wire logic [NUM_CMP-1:0][TW-1:0] chan_reload,
	input wire logic [NUM_CMP-1:0] channel_compare_enable_field,
	input wire logic [NUM_CAP-1:0] capture_enable,
	input wire logic [NUM_CAP-1:0] capture_mode,
	input wire logic [NUM_CAP-1:0][1:0] capture_edge_sel,
	input wire logic [1:0] compare_mode_select,
	input wire logic group_a_polarity,
	input wire logic group_b_polarity,
	input wire logic [NUM_CMP-1:0] cmp_int_en,
	input wire logic [NUM_CMP-1:0] shadow_wr_lo,
	input wire logic [NUM_CMP-1:0] shadow_wr_hi,
	input wire logic [7:0] shadow_wr_byte,
	input wire logic shadow_ctrl_wr,
	input wire logic [7:0] shadow_ctrl_wdata,
	input wire logic [NUM_CAP-1:0] capture_pin,
	input wire logic [NUM_CAP-1:0] capture_sw_trig,
	output logic [NUM_CMP-1:0][TW-1:0] compare_value_shadow_reg,
	output logic [7:0] compare_shadow_ctrl_reg,
	output logic [NUM_CAP-1:0][TW-1:0] capture_value,
	output logic [NUM_CMP-1:0] cmp_pin_o,
	output logic [NUM_CMP-1:0] cmp_pin_oe,
	output logic [NUM_CAP-1:0] ext_int_req,
	output logic [NUM_CMP-1:0] cmp_int_req
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Group A holds even channels, group B odd ones
	function automatic logic active_level(input int ch, input logic pol_a, input logic pol_b);
		active_level = (ch % 2 == 0) ? pol_a : pol_b;
	endfunction : active_level

	// Edge detect against the chosen trigger edge
	function automatic logic edge_hit(input logic [1:0] sel, input logic now_v,
			input logic old_v);
		edge_hit = 1'b0;
		unique case (cc_pkg::cc_edge_e'(sel))
			cc_pkg::CC_EDGE_NONE: edge_hit = 1'b0;
			cc_pkg::CC_EDGE_RISE: edge_hit = now_v && !old_v;
			cc_pkg::CC_EDGE_FALL: edge_hit = !now_v && old_v;
			cc_pkg::CC_EDGE_BOTH: edge_hit = now_v ^ old_v;
		endcase
	endfunction : edge_hit

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	cc_pkg::cc_cmode_e mode;
	logic shadow_on_overflow_q;
	logic ensw_q;
	logic [NUM_CMP-1:0] coout_q;
	logic [NUM_CMP-1:0] hidden_q;
	logic [NUM_CMP-1:0][TW-1:0] shadow_q;
	logic [NUM_CMP-1:0] en_q;
	logic [NUM_CMP-1:0] en_rise;
	logic [NUM_CMP-1:0] out_q;
	logic [NUM_CMP-1:0] out_d;
	logic [NUM_CMP-1:0] rise;
	logic [NUM_CMP-1:0][TW-1:0] cmp_val;
	logic [NUM_CAP-1:0] cap_s1_q;
	logic [NUM_CAP-1:0] cap_s2_q;
	logic [NUM_CAP-1:0] cap_s3_q;
	logic [NUM_CAP-1:0] cap_hit;
	logic [NUM_CAP-1:0] cap_take_q;
	logic [NUM_CAP-1:0] cap_irq_q;
	logic [2:0] cap_warm_q;
	logic wr_ensw;
	logic wr_shadow_on_overflow;

	// One mode for every enabled compare channel
	assign mode = cc_pkg::cc_cmode_e'(compare_mode_select);

	// ----------------------------------------------------------------
	// Shadow control word
	// ----------------------------------------------------------------
	assign wr_shadow_on_overflow = shadow_ctrl_wdata[`CC_SHC_SHADOW_ON_OVERFLOW];
	assign wr_ensw = shadow_ctrl_wdata[`CC_SHC_ENSW];

	// Trigger selects; overflow trigger forces the software one off
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shadow_on_overflow_q <= 1'b0;
			ensw_q <= 1'b0;
		end else if (shadow_ctrl_wr) begin
			shadow_on_overflow_q <= wr_shadow_on_overflow;
			ensw_q <= wr_ensw && !wr_shadow_on_overflow;
		end else if (shadow_on_overflow_q) begin
			ensw_q <= 1'b0;
		end
	end

	// Output bits act as transfer strobes, high for one cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			coout_q <= `CC_OUT_RST;
		end else if (shadow_ctrl_wr && wr_ensw && !wr_shadow_on_overflow) begin
			coout_q <= shadow_ctrl_wdata[`CC_SHC_OUT_HI:`CC_SHC_OUT_LO];
		end else begin
			coout_q <= `CC_OUT_RST;
		end
	end

	// With software trigger off the bits land in the hidden register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hidden_q <= `CC_OUT_RST;
		end else if (shadow_ctrl_wr && !(wr_ensw && !wr_shadow_on_overflow)) begin
			hidden_q <= shadow_ctrl_wdata[`CC_SHC_OUT_HI:`CC_SHC_OUT_LO];
		end
	end

	// Read view follows the same routing as writes
	assign compare_shadow_ctrl_reg = {shadow_on_overflow_q, ensw_q, ensw_q ? coout_q : hidden_q};

	// ----------------------------------------------------------------
	// Compare value shadow registers
	// ----------------------------------------------------------------
	// Byte writes go here only; the live compare value never sees them
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shadow_q <= '0;
		end else begin
			for (int i = 0; i < NUM_CMP; i++) begin
				if (shadow_wr_lo[i]) begin
					shadow_q[i][7:0] <= shadow_wr_byte;
				end
				if (shadow_wr_hi[i]) begin
					shadow_q[i][TW-1:8] <= shadow_wr_byte;
				end
			end
		end
	end

	assign compare_value_shadow_reg = shadow_q;

	// ----------------------------------------------------------------
	// Compare cores
	// ----------------------------------------------------------------
	// Full-width count keeps all 65536 steps per channel
	for (genvar g = 0; g < NUM_CMP; g++) begin : g_cmp
		cc_cmp_if link ();

		assign link.count = chan_count[g];
		assign link.shadow = shadow_q[g];
		// Overflow or output-bit strobe starts the load
		assign link.xfer_evt = shadow_on_overflow_q ? chan_ovf[g] : (ensw_q && coout_q[g]);
		assign cmp_val[g] = link.cmp;
		assign rise[g] = link.match_rise && channel_compare_enable_field[g];

		cc_cmp_core u_core (
			.clk(clk),
			.rst_n(rst_n),
			.bus(link.core)
		);
	end

	// ----------------------------------------------------------------
	// Compare output logic
	// ----------------------------------------------------------------
	// Enable edge latches the initial level
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			en_q <= '0;
		end else begin
			en_q <= channel_compare_enable_field;
		end
	end

	assign en_rise = channel_compare_enable_field & ~en_q;

	// Next output level; combinational so the pin moves in the match cycle
	always_comb begin
		logic act;
		act = 1'b0;
		out_d = out_q;
		for (int i = 0; i < NUM_CMP; i++) begin
			act = active_level(i, group_a_polarity, group_b_polarity);
			if (!channel_compare_enable_field[i]) begin
				out_d[i] = !act;
			end else begin
				unique case (mode)
					cc_pkg::CC_MODE0: begin
						if (en_rise[i]) begin
							// At or past the value already means active
							out_d[i] = (chan_count[i] >= cmp_val[i]) ? act : !act;
						end else if (rise[i]) begin
							out_d[i] = act;
						end else if (chan_ovf[i] && (cmp_val[i] != chan_reload[i])) begin
							// Value equal to reload holds active for full duty
							out_d[i] = !act;
						end
					end
					cc_pkg::CC_MODE1: begin
						if (en_rise[i] || rise[i]) begin
							out_d[i] = hidden_q[i];
						end
					end
					cc_pkg::CC_MODE_CONC: begin
						// Channel 0 match updates every enabled output at once
						if (en_rise[i] || rise[0]) begin
							out_d[i] = hidden_q[i];
						end
					end
					default: begin
						out_d[i] = out_q[i];
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_q <= `CC_OUT_RST;
		end else begin
			out_q <= out_d;
		end
	end

	// Pin shows the new level in the same cycle as the match edge
	assign cmp_pin_o = out_d;
	// Undriven until the compare function is enabled
	assign cmp_pin_oe = channel_compare_enable_field;
	// Match edge raises the request when enabled
	assign cmp_int_req = rise & cmp_int_en;

	// ----------------------------------------------------------------
	// Capture inputs
	// ----------------------------------------------------------------
	// Two-stage synchroniser, then a third stage for the edge compare
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cap_s1_q <= '0;
			cap_s2_q <= '0;
			cap_s3_q <= '0;
		end else begin
			cap_s1_q <= capture_pin;
			cap_s2_q <= cap_s1_q;
			cap_s3_q <= cap_s2_q;
		end
	end

	// Edges count only once the history holds real samples; a pin that
	// idles high would otherwise fake a rising edge right after reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cap_warm_q <= '0;
		end else begin
			cap_warm_q <= {cap_warm_q[1:0], 1'b1};
		end
	end

	// A compare-enabled pin is an output, so its capture is suppressed
	always_comb begin
		cap_hit = '0;
		for (int i = 0; i < NUM_CAP; i++) begin
			if (capture_enable[i] && !channel_compare_enable_field[i]) begin
				if (capture_mode[i]) begin
					cap_hit[i] = capture_sw_trig[i];
				end else begin
					cap_hit[i] = cap_warm_q[2]
						&& edge_hit(capture_edge_sel[i], cap_s2_q[i], cap_s3_q[i]);
				end
			end
		end
	end

	// Timer is latched in the cycle after the edge was seen
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cap_take_q <= '0;
			cap_irq_q <= '0;
		end else begin
			cap_take_q <= cap_hit;
			cap_irq_q <= cap_hit & ~capture_mode; // Software capture raises no request
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			capture_value <= '0;
		end else begin
			for (int i = 0; i < NUM_CAP; i++) begin
				if (cap_take_q[i]) begin
					capture_value[i] <= chan_count[i];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Shared external interrupt lines
	// ----------------------------------------------------------------
	// Channels 0..3 own the lines; 4 and 5 have no capture side
	always_comb begin
		for (int i = 0; i < NUM_CAP; i++) begin
			ext_int_req[i] = channel_compare_enable_field[i] ? rise[i] : cap_irq_q[i];
		end
	end

endmodule : cc_chan

`default_nettype wire

// ===== src/cc_consts.svh
// Constants for the capture/compare channel block: counts, widths,
// field positions and reset values.
// Assumes inclusion by bare name from every file that needs them.
`ifndef CC_CONSTS_SVH
`define CC_CONSTS_SVH

// ----------------------------------------------------------------
// Channel counts and widths
// ----------------------------------------------------------------
`define CC_NUM_CMP 6
`define CC_NUM_CAP 4
`define CC_TIMER_W 16
`define CC_STEPS 65536

// ----------------------------------------------------------------
// Shadow control word: bit 7 overflow trigger, bit 6 software trigger,
// bits 5..0 channel output bits
// ----------------------------------------------------------------
`define CC_SHC_SHADOW_ON_OVERFLOW 7
`define CC_SHC_ENSW 6
`define CC_SHC_OUT_HI 5
`define CC_SHC_OUT_LO 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CC_CMP_RST 16'h0000
`define CC_OUT_RST 6'h00
`define CC_CAP_RST 16'h0000

`endif

// ===== src/cc_pkg.sv
// Types shared by the capture/compare channel files.
// Assumes nothing of its surroundings.
`default_nettype none

package cc_pkg;

	// Compare mode, one field for all compare channels
	typedef enum logic [1:0] {
		CC_MODE0 = 2'h0,
		CC_MODE1 = 2'h1,
		CC_MODE_CONC = 2'h2
	} cc_cmode_e;

	// Capture edge choice, taken from the shared interrupt setup
	typedef enum logic [1:0] {
		CC_EDGE_NONE = 2'h0,
		CC_EDGE_RISE = 2'h1,
		CC_EDGE_FALL = 2'h2,
		CC_EDGE_BOTH = 2'h3
	} cc_edge_e;

	typedef logic [15:0] cc_count_t;

endpackage : cc_pkg

`default_nettype wire

// ===== src/cc_cmp_if.sv
// Carrier between the top block and one compare core.
// Assumes both ends run on the same clock.
`default_nettype none

interface cc_cmp_if;
	cc_pkg::cc_count_t count;
	cc_pkg::cc_count_t shadow;
	logic xfer_evt;
	cc_pkg::cc_count_t cmp;
	logic match;
	logic match_rise;

	modport core (
		input count,
		input shadow,
		input xfer_evt,
		output cmp,
		output match,
		output match_rise
	);

	modport top (
		output count,
		output shadow,
		output xfer_evt,
		input cmp,
		input match,
		input match_rise
	);
endinterface : cc_cmp_if

`default_nettype wire

// ===== src/cc_cmp_core.sv
// One compare core: hidden compare register with shadow load, comparator
// and match edge detector.
// Assumes count and transfer event come from logic on the same clock.
`default_nettype none

`include "cc_consts.svh"

module cc_cmp_core (
	input wire logic clk,
	input wire logic rst_n,
	cc_cmp_if.core bus
);

	logic evt_q;
	logic match_q;
	cc_pkg::cc_count_t cmp_q;

	// ----------------------------------------------------------------
	// Shadow transfer
	// ----------------------------------------------------------------
	// Only the rising edge of the trigger loads; a held trigger loads once
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			evt_q <= 1'b0;
		end else begin
			evt_q <= bus.xfer_evt;
		end
	end

	// Whole word in one edge, never a half-updated value
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cmp_q <= `CC_CMP_RST;
		end else if (bus.xfer_evt && !evt_q) begin
			cmp_q <= bus.shadow;
		end
	end

	// ----------------------------------------------------------------
	// Comparator
	// ----------------------------------------------------------------
	// Match stays high while equal; only its rising edge acts
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			match_q <= 1'b0;
		end else begin
			match_q <= bus.match;
		end
	end

	assign bus.cmp = cmp_q;
	assign bus.match = (bus.count == cmp_q);
	assign bus.match_rise = bus.match && !match_q;

endmodule : cc_cmp_core

`default_nettype wire

// ===== sim/cc_chan_asserts.sv
// Checker for the capture/compare channel block.
// Assumes it is bound to cc_chan and sees only its ports.
`default_nettype none

module cc_chan_asserts #(
	parameter int NUM_CMP = 6,
	parameter int TW = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [NUM_CMP-1:0] channel_compare_enable_field,
	input wire logic [1:0] compare_mode_select,
	input wire logic group_a_polarity,
	input wire logic group_b_polarity,
	input wire logic [NUM_CMP-1:0] cmp_int_en,
	input wire logic [NUM_CMP-1:0] shadow_wr_lo,
	input wire logic [7:0] shadow_wr_byte,
	input wire logic shadow_ctrl_wr,
	input wire logic [7:0] shadow_ctrl_wdata,
	input wire logic [NUM_CMP-1:0][TW-1:0] compare_value_shadow_reg,
	input wire logic [7:0] compare_shadow_ctrl_reg,
	input wire logic [NUM_CMP-1:0] cmp_pin_o,
	input wire logic [NUM_CMP-1:0] cmp_pin_oe,
	input wire logic [NUM_CMP-1:0] cmp_int_req
);
	timeunit 1ns;
	timeprecision 100ps;
	// --------
	// Properties
	// --------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_oe;
		cmp_pin_oe == channel_compare_enable_field;
	endproperty
	a_oe: assert property (p_oe) else $error("oe not following enable");

	// Strobe bits show for one cycle, then read back as zero
	property p_sw;
		shadow_ctrl_wr && shadow_ctrl_wdata[7:6] == 2'h1 |=>
			compare_shadow_ctrl_reg == $past(shadow_ctrl_wdata) ##1
			($past(shadow_ctrl_wr) || compare_shadow_ctrl_reg[5:0] == 6'h00);
	endproperty
	a_sw: assert property (p_sw) else $error("strobe bits not self clearing");

	property p_shadow_on_overflow;
		shadow_ctrl_wr && shadow_ctrl_wdata[7] |=> compare_shadow_ctrl_reg[7:6] == 2'h2;
	endproperty
	a_shadow_on_overflow: assert property (p_shadow_on_overflow) else $error("software bit kept with overflow");

	property p_lo;
		shadow_wr_lo[0] |=> compare_value_shadow_reg[0][7:0] == $past(shadow_wr_byte);
	endproperty
	a_lo: assert property (p_lo) else $error("shadow low byte lost");

	property p_gate;
		(cmp_int_req & ~cmp_int_en) == '0;
	endproperty
	a_gate: assert property (p_gate) else $error("request while disabled");

	property p_pulse;
		cmp_int_req[0] |=> !cmp_int_req[0];
	endproperty
	a_pulse: assert property (p_pulse) else $error("request longer than a cycle");

	property p_match_a;
		compare_mode_select == 2'h0 && cmp_int_req[0] |-> cmp_pin_o[0] == group_a_polarity;
	endproperty
	a_match_a: assert property (p_match_a) else $error("group A match level");

	property p_match_b;
		compare_mode_select == 2'h0 && cmp_int_req[1] |-> cmp_pin_o[1] == group_b_polarity;
	endproperty
	a_match_b: assert property (p_match_b) else $error("group B match level");

	property p_idle;
		!channel_compare_enable_field[0] |-> cmp_pin_o[0] != group_a_polarity;
	endproperty
	a_idle: assert property (p_idle) else $error("disabled pin not inactive");

	c_match: cover property (cmp_int_req[0]);
	c_sw: cover property (shadow_ctrl_wr && shadow_ctrl_wdata[7:6] == 2'h1);
	c_shadow_on_overflow: cover property (compare_shadow_ctrl_reg[7]);
endmodule : cc_chan_asserts

bind cc_chan cc_chan_asserts #(.NUM_CMP(NUM_CMP), .TW(TW)) u_chk (
	.clk(clk), .rst_n(rst_n), .channel_compare_enable_field(channel_compare_enable_field),
	.compare_mode_select(compare_mode_select), .group_a_polarity(group_a_polarity),
	.group_b_polarity(group_b_polarity), .cmp_int_en(cmp_int_en), .shadow_wr_lo(shadow_wr_lo),
	.shadow_wr_byte(shadow_wr_byte), .shadow_ctrl_wr(shadow_ctrl_wr),
	.shadow_ctrl_wdata(shadow_ctrl_wdata), .compare_value_shadow_reg(compare_value_shadow_reg),
	.compare_shadow_ctrl_reg(compare_shadow_ctrl_reg), .cmp_pin_o(cmp_pin_o),
	.cmp_pin_oe(cmp_pin_oe), .cmp_int_req(cmp_int_req)
);

`default_nettype wire

// ===== sim/cc_pin_model.sv
// Far-side model: capture signal sources and compare output loads.
// Assumes the bench sets the wanted capture levels.
`default_nettype none

module cc_pin_model (
	input wire logic [3:0] want,
	input wire logic [5:0] cmp_pin_o,
	input wire logic [5:0] cmp_pin_oe,
	output logic [3:0] capture_pin,
	output logic [5:0] load_level
);
	timeunit 1ns;
	timeprecision 100ps;
	// Sources switch 7 ns late, out of step with the unit clock
	assign #7 capture_pin = want;
	// Loads have pull-downs, so an undriven pin reads low
	assign load_level = cmp_pin_o & cmp_pin_oe;
endmodule : cc_pin_model

`default_nettype wire

// ===== sim/capture_compare_channels_bench.sv
// Self-checking bench for the capture/compare channel block.
// Assumes cc_chan, its checker and the pin model are compiled first.
`default_nettype none

module capture_compare_channels_bench;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk;
	logic rst_n;
	logic [5:0][15:0] cnt;
	logic [5:0][15:0] rel;
	logic [5:0][15:0] shd;
	logic [3:0][15:0] cap;
	logic [3:0][1:0] esel;
	logic [5:0] ovf, en, ie, wlo, whi, pin, oe, ireq, lvl;
	logic [3:0] cen, cmod, want, cpin, strig, ext, got;
	logic [7:0] wb, wd, ctrl;
	logic [1:0] mode;
	logic pa, pb, cwr, act;
	logic [15:0] v, xc;
	int n_fail, comparisons, seed;

	cc_chan dut (
		.clk(clk), .rst_n(rst_n), .chan_count(cnt), .chan_ovf(ovf), .chan_reload(rel),
		.channel_compare_enable_field(en), .capture_enable(cen), .capture_mode(cmod),
		.capture_edge_sel(esel), .compare_mode_select(mode), .group_a_polarity(pa),
		.group_b_polarity(pb), .cmp_int_en(ie), .shadow_wr_lo(wlo), .shadow_wr_hi(whi),
		.shadow_wr_byte(wb), .shadow_ctrl_wr(cwr), .shadow_ctrl_wdata(wd),
		.capture_pin(cpin), .capture_sw_trig(strig), .compare_value_shadow_reg(shd),
		.compare_shadow_ctrl_reg(ctrl), .capture_value(cap), .cmp_pin_o(pin),
		.cmp_pin_oe(oe), .ext_int_req(ext), .cmp_int_req(ireq)
	);
	cc_pin_model u_pins (
		.want(want), .cmp_pin_o(pin), .cmp_pin_oe(oe), .capture_pin(cpin), .load_level(lvl)
	);

	// 40 MHz unit clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// --------
	// Tasks
	// --------
	task automatic check(input logic [15:0] s, input logic [15:0] e);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("Error at %0t: saw %h, want %h", $time, s, e);
		end
	endtask : check

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude

	task automatic ctl(input logic [7:0] d);
		cwr = 1'b1;
		wd = d;
		@(negedge clk);
		cwr = 1'b0;
	endtask : ctl

	// Low byte then high byte; live compare stays put until a transfer
	task automatic wsh(input int ch, input logic [15:0] d);
		wlo = 6'h01 << ch;
		wb = d[7:0];
		@(negedge clk);
		wlo = 6'h00;
		whi = 6'h01 << ch;
		wb = d[15:8];
		@(negedge clk);
		whi = 6'h00;
		check(shd[ch], d);
	endtask : wsh

	task automatic load(input int ch, input logic [15:0] d);
		logic [7:0] w;
		w = {2'h1, 6'(6'h01 << ch)};
		wsh(ch, d);
		ctl(w);
		check(ctrl, w);
		@(negedge clk);
		check(ctrl, 8'h40);
	endtask : load

	// Gathers external request pulses over eight cycles
	task automatic watch();
		got = 4'h0;
		repeat (8) begin
			@(negedge clk);
			got = got | ext;
		end
	endtask : watch

	// --------
	// Main sequence
	// --------
	initial begin
		seed = 18;
		rst_n = 1'b0;
		{cnt, rel, ovf, en, wlo, whi, wb, wd, cwr, mode, cen, cmod, esel, want, strig} = '0;
		ie = 6'h03 | 6'($random(seed));
		pa = 1'($random(seed));
		pb = 1'($random(seed));
		n_fail = 0;
		comparisons = 0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		// Mode 0 on every channel: enable below value, match, overflow
		for (int ch = 0; ch < 6; ch++) begin
			act = ch[0] ? pb : pa;
			v = 16'h0100 | 16'($random(seed));
			load(ch, v);
			cnt[ch] = v - 16'h0001;
			rel[ch] = v - 16'h0001;
			en[ch] = 1'b1;
			@(negedge clk);
			check(pin[ch], !act);
			check(oe[ch], 1'b1);
			cnt[ch] = v;
			#1;
			check(pin[ch], act);
			check(ireq[ch], ie[ch]);
			if (ch < 4) begin
				check(ext[ch], 1'b1);
			end
			@(negedge clk);
			cnt[ch] = rel[ch];
			ovf[ch] = 1'b1;
			#1;
			check(pin[ch], !act);
			@(negedge clk);
			ovf[ch] = 1'b0;
			en[ch] = 1'b0;
			@(negedge clk);
			check(lvl[ch], 1'b0);
		end
		// Both trigger bits written at once: overflow trigger must win
		ctl(8'hC0);
		check(ctrl, 8'h80);
		wsh(2, 16'h0010);
		cnt[2] = 16'h0010;
		rel[2] = 16'h0010;
		ovf[2] = 1'b1;
		@(negedge clk);
		ovf[2] = 1'b0;
		en[2] = 1'b1;
		@(negedge clk);
		check(pin[2], pa);
		ovf[2] = 1'b1;
		@(negedge clk);
		ovf[2] = 1'b0;
		check(pin[2], pa);
		en[2] = 1'b0;
		// Hidden output bits steer mode 1 and concurrent mode
		ctl(8'h05);
		check(ctrl, 8'h05);
		for (int m = 1; m < 3; m++) begin
			mode = 2'(m);
			en[m-1] = 1'b1;
			@(negedge clk);
			check(pin[m-1], m == 1);
			en[m-1] = 1'b0;
			@(negedge clk);
		end
		// Code 3 holds every enabled output where it stands, enable edge included
		mode = 2'h3;
		en[2] = 1'b1;
		@(negedge clk);
		check(pin[2], !pa);
		en[2] = 1'b0;
		mode = 2'h0;
		// Zero duty: value under a non-zero reload never matches
		load(4, 16'h0005);
		cnt[4] = 16'h0100;
		rel[4] = 16'h0100;
		en[4] = 1'b1;
		@(negedge clk);
		check(pin[4], pa);
		ovf[4] = 1'b1;
		@(negedge clk);
		ovf[4] = 1'b0;
		repeat (4) begin
			cnt[4] = cnt[4] + 16'h0001;
			@(negedge clk);
			check(pin[4], !pa);
		end
		en[4] = 1'b0;
		// Edge captures on channel 3; channel 2 toggles but stays disabled
		cen = 4'h8;
		esel[2] = 2'h3;
		xc = 16'h0000;
		for (int k = 0; k < 4; k++) begin
			esel[3] = {k[0], k[1]};
			cnt[3] = 16'($random(seed));
			want = ~want & 4'hC;
			watch();
			xc = (k != 0) ? cnt[3] : xc;
			check(got, (k != 0) ? 4'h8 : 4'h0);
			check(cap[3], xc);
		end
		// Software capture raises no request
		cmod[3] = 1'b1;
		cnt[3] = 16'($random(seed));
		strig[3] = 1'b1;
		@(negedge clk);
		strig[3] = 1'b0;
		watch();
		check(got, 4'h0);
		check(cap[3], cnt[3]);
		conclude();
	end

	// Cuts a hang short, far past the roughly 113 cycles expected
	initial begin
		#50000;
		n_fail++;
		conclude();
	end
endmodule : capture_compare_channels_bench

`default_nettype wire
